// ---- common/smc_params.svh ----
// Constants of the standby-mode controller: offsets, bit positions, resets
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// Register indices; byte address is four times the index
`define SMC_IDX_POWER_SAVE_CONTROL 32'hFFFFF1FE
`define SMC_IDX_PSC_SET            32'hFFFFF1F0
`define SMC_IDX_PSC_CLEAR          32'hFFFFF1F1
`define SMC_IDX_POWER_SAVE_MODE    32'hFFFFF1F8
`define SMC_IDX_CLOCK_CONTROL      32'hFFFFF1F9
`define SMC_IDX_STATUS             32'hFFFFF1FA
`define SMC_IDX_PROTECT_COMMAND    32'hFFFFF1FC
`define SMC_BYTE_ADDR(i)           {(i), 2'b00}

// Field positions of power_save_control
`define SMC_PSC_WDT2_BLOCK_BIT     7
`define SMC_PSC_PIN_BLOCK_BIT      5
`define SMC_PSC_MASK_BLOCK_BIT     4
`define SMC_PSC_STANDBY_BIT        1

// Field positions of the other registers
`define SMC_POWER_SAVE_MODE_REG_CHOICE_BIT        0
`define SMC_CLK_SUBSEL_BIT         0
`define SMC_CLK_PLLEN_BIT          1
`define SMC_STAT_ARMED_BIT         3
`define SMC_STAT_ONSUB_BIT         4

// Reset values
`define SMC_PSC_RESET              8'h00
`define SMC_CLK_OUT_RESET          6'h3A

`endif

// ---- common/smc_pkg.sv ----
// Types of the standby-mode controller
`default_nettype none
package smc_pkg;

    // Operating and low-power modes
    typedef enum logic [2:0] {
        SMC_NORMAL  = 3'h0,
        SMC_HALT    = 3'h1,
        SMC_IDLE    = 3'h2,
        SMC_STOP    = 3'h3,
        SMC_SUB     = 3'h4,
        SMC_SUBIDLE = 3'h5
    } smc_mode_e;

    // Clock and oscillator enables towards the clock generator
    typedef struct packed {
        logic cpuClkEn;
        logic periphClkEn;
        logic mainOscEn;
        logic pllEn;
        logic subOscEn;
        logic sysClkSel;
    } smc_clk_s;

    // Fields of power_save_control
    typedef struct packed {
        logic wdt2ReleaseBlock;
        logic pinNonmaskReleaseBlock;
        logic maskableReleaseBlock;
        logic standbySelect;
    } smc_psc_s;

    // Wake sources, all active high levels
    typedef struct packed {
        logic       nmiPin;
        logic       watchdog1NonmaskRequest;
        logic       watchdog2NonmaskRequest;
        logic       maskableIrq;
        logic [7:0] externalIrqPins;
        logic       idlePeriphIrq;
        logic       stopPeriphIrq;
        logic       subIdlePeriphIrq;
    } smc_wake_s;

    // Reset sources other than the reset pin
    typedef struct packed {
        logic watchdog1Reset;
        logic watchdog2Reset;
    } smc_rst_s;

    // Avalon-MM request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [33:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } smc_avs_req_s;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } smc_avs_rsp_s;

    // Whole state of the controller
    typedef struct packed {
        smc_mode_e   mode;
        smc_psc_s    power_save_control;
        logic        idleOrStopChoice;
        logic        subclockSelect;
        logic        pllEnable;
        logic        armed;
        logic        ack;
        logic [31:0] rdata;
        smc_clk_s    clk;
        logic        sysResetReq;
        logic        wakePulse;
    } smc_state_s;

endpackage
`default_nettype wire

// ---- src/smc_standby_controller.sv ----
// Standby-mode controller with protected power-save register on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_standby_controller (
    // Clock, reset and clock enable
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    // Register bus
    input  wire smc_pkg::smc_avs_req_s avsReq,
    output var  smc_pkg::smc_avs_rsp_s avsRsp,
    // CPU halt command, one-cycle pulse
    input  wire logic          haltCommand,
    // Wake and reset sources
    input  wire smc_pkg::smc_wake_s    wakeSrc,
    input  wire smc_pkg::smc_rst_s     rstSrc,
    // Clock generator controls
    output var  smc_pkg::smc_clk_s     clkCtl,
    // Mode and events
    output var  smc_pkg::smc_mode_e    mode,
    output logic               sysResetReq,
    output logic               wakePulse
);
    import smc_pkg::*;

    smc_state_s s_r;
    smc_state_s s_nxt;
    logic       busReq;
    logic       taken;
    logic       laneLow;
    logic       onSubclock;
    logic       anyReset;
    logic       maskableWake;
    logic       pinWake;
    logic       wdt2Wake;
    logic       haltWake;
    logic       idleWake;
    logic       stopWake;
    logic       subIdleWake;
    logic       pscSet;
    logic [7:0] pscByte;
    logic [7:0] statusByte;
    logic [33:0] addr;

    // Clock enables for each mode; the PLL follows software except in stop
    function automatic smc_clk_s clocksFor(smc_mode_e m, logic pll);
        smc_clk_s c;
        c = smc_clk_s'(`SMC_CLK_OUT_RESET);
        c.pllEn = pll;
        unique case (m)
            SMC_NORMAL: begin
                c.cpuClkEn = 1'b1;
            end
            SMC_HALT: begin
                c.cpuClkEn = 1'b0;
            end
            SMC_IDLE: begin
                c.cpuClkEn    = 1'b0;
                c.periphClkEn = 1'b0;
            end
            SMC_STOP: begin
                c.cpuClkEn    = 1'b0;
                c.periphClkEn = 1'b0;
                c.mainOscEn   = 1'b0;
                c.pllEn       = 1'b0;
            end
            SMC_SUB: begin
                c.sysClkSel = 1'b1;
            end
            SMC_SUBIDLE: begin
                c.sysClkSel   = 1'b1;
                c.cpuClkEn    = 1'b0;
                c.periphClkEn = 1'b0;
            end
            default: begin
                c = smc_clk_s'(`SMC_CLK_OUT_RESET);
            end
        endcase
        return c;
    endfunction

    // New register content; masks that ride with standby-select are dropped
    function automatic smc_psc_s pscUpdate(smc_psc_s old, logic [7:0] v,
                                           logic [7:0] ones);
        smc_psc_s n;
        n.wdt2ReleaseBlock       = v[`SMC_PSC_WDT2_BLOCK_BIT];
        n.pinNonmaskReleaseBlock = v[`SMC_PSC_PIN_BLOCK_BIT];
        n.maskableReleaseBlock   = v[`SMC_PSC_MASK_BLOCK_BIT];
        n.standbySelect          = v[`SMC_PSC_STANDBY_BIT];
        if (n.standbySelect && (ones[`SMC_PSC_WDT2_BLOCK_BIT] ||
                                ones[`SMC_PSC_PIN_BLOCK_BIT] ||
                                ones[`SMC_PSC_MASK_BLOCK_BIT])) begin
            n.wdt2ReleaseBlock       = old.wdt2ReleaseBlock;
            n.pinNonmaskReleaseBlock = old.pinNonmaskReleaseBlock;
            n.maskableReleaseBlock   = old.maskableReleaseBlock;
        end
        return n;
    endfunction

    // Bus handshake: one wait state, frozen with the clock enable
    assign busReq  = avsReq.read | avsReq.write;
    assign taken   = busReq & s_r.ack & ce;
    assign laneLow = avsReq.byteenable[0];
    assign addr    = avsReq.address;

    // Reset routing depends on which clock the CPU runs from
    assign onSubclock = (s_r.mode == SMC_SUB) || (s_r.mode == SMC_SUBIDLE);
    assign anyReset   = rstSrc.watchdog2Reset |
                        (rstSrc.watchdog1Reset & ~onSubclock);

    // Wake terms; all but the halt wake are gated by the release block bits
    assign pinWake  = wakeSrc.nmiPin &
                      ~s_r.power_save_control.pinNonmaskReleaseBlock;
    assign wdt2Wake = wakeSrc.watchdog2NonmaskRequest &
                      ~s_r.power_save_control.wdt2ReleaseBlock;
    assign maskableWake = ~s_r.power_save_control.maskableReleaseBlock;
    assign haltWake = wakeSrc.nmiPin | wakeSrc.watchdog1NonmaskRequest |
                      wakeSrc.watchdog2NonmaskRequest |
                      wakeSrc.maskableIrq;
    // Watchdog 2 never wakes idle or stop, as onSubclock is low in both modes
    assign idleWake = pinWake | (wdt2Wake & onSubclock) |
                      (maskableWake & ((|wakeSrc.externalIrqPins) |
                                       wakeSrc.idlePeriphIrq));
    assign stopWake = pinWake | (wdt2Wake & onSubclock) |
                      (maskableWake & ((|wakeSrc.externalIrqPins) |
                                       wakeSrc.stopPeriphIrq));
    assign subIdleWake = pinWake | wdt2Wake |
                         (maskableWake & ((|wakeSrc.externalIrqPins) |
                                          wakeSrc.subIdlePeriphIrq));

    // Read views of the registers; unused bits read zero
    always_comb begin
        pscByte = 8'h00;
        pscByte[`SMC_PSC_WDT2_BLOCK_BIT] = s_r.power_save_control.wdt2ReleaseBlock;
        pscByte[`SMC_PSC_PIN_BLOCK_BIT]  = s_r.power_save_control.pinNonmaskReleaseBlock;
        pscByte[`SMC_PSC_MASK_BLOCK_BIT] = s_r.power_save_control.maskableReleaseBlock;
        pscByte[`SMC_PSC_STANDBY_BIT]    = s_r.power_save_control.standbySelect;
        statusByte = {5'h00, s_r.mode};
        statusByte[`SMC_STAT_ARMED_BIT] = s_r.armed;
        statusByte[`SMC_STAT_ONSUB_BIT] = onSubclock;
    end

    // Next state: bus, protected writes, mode sequencing, resets
    always_comb begin
        s_nxt = s_r;
        s_nxt.sysResetReq = 1'b0;
        s_nxt.wakePulse   = 1'b0;
        pscSet            = 1'b0;
        s_nxt.ack = busReq & ~s_r.ack;
        // Read data captured in the first cycle, stands at the answer
        if (busReq & ~s_r.ack) begin
            unique case (addr)
                `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_CONTROL),
                `SMC_BYTE_ADDR(`SMC_IDX_PSC_SET),
                `SMC_BYTE_ADDR(`SMC_IDX_PSC_CLEAR): begin
                    s_nxt.rdata = {24'h000000, pscByte};
                end
                `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_MODE): begin
                    s_nxt.rdata = {31'h00000000, s_r.idleOrStopChoice};
                end
                `SMC_BYTE_ADDR(`SMC_IDX_CLOCK_CONTROL): begin
                    s_nxt.rdata = {30'h00000000, s_r.pllEnable,
                                   s_r.subclockSelect};
                end
                `SMC_BYTE_ADDR(`SMC_IDX_STATUS): begin
                    s_nxt.rdata = {24'h000000, statusByte};
                end
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
        // Any completed write uses up the protect arming
        if (taken && avsReq.write) begin
            s_nxt.armed = 1'b0;
            if (laneLow) begin
                unique case (addr)
                    `SMC_BYTE_ADDR(`SMC_IDX_PROTECT_COMMAND): begin
                        s_nxt.armed = 1'b1;
                    end
                    `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_CONTROL): begin
                        if (s_r.armed) begin
                            s_nxt.power_save_control = pscUpdate(s_r.power_save_control,
                                avsReq.writedata[7:0],
                                avsReq.writedata[7:0]);
                            pscSet = avsReq.writedata[`SMC_PSC_STANDBY_BIT];
                        end
                    end
                    `SMC_BYTE_ADDR(`SMC_IDX_PSC_SET): begin
                        if (s_r.armed) begin
                            s_nxt.power_save_control = pscUpdate(s_r.power_save_control,
                                pscByte | avsReq.writedata[7:0],
                                avsReq.writedata[7:0]);
                            pscSet = avsReq.writedata[`SMC_PSC_STANDBY_BIT];
                        end
                    end
                    `SMC_BYTE_ADDR(`SMC_IDX_PSC_CLEAR): begin
                        if (s_r.armed) begin
                            s_nxt.power_save_control = pscUpdate(s_r.power_save_control,
                                pscByte & ~avsReq.writedata[7:0],
                                8'h00);
                        end
                    end
                    `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_MODE): begin
                        s_nxt.idleOrStopChoice =
                            avsReq.writedata[`SMC_POWER_SAVE_MODE_REG_CHOICE_BIT];
                    end
                    `SMC_BYTE_ADDR(`SMC_IDX_CLOCK_CONTROL): begin
                        s_nxt.subclockSelect =
                            avsReq.writedata[`SMC_CLK_SUBSEL_BIT];
                        s_nxt.pllEnable =
                            avsReq.writedata[`SMC_CLK_PLLEN_BIT];
                    end
                    default: s_nxt.armed = 1'b0;
                endcase
            end
        end
        // Mode sequencing; a wake from idle, stop or subclock idle clears standby-select unless a write sets it
        unique case (s_r.mode)
            SMC_NORMAL: begin
                if (s_r.power_save_control.standbySelect) begin
                    s_nxt.mode = s_r.idleOrStopChoice ? SMC_STOP
                                                      : SMC_IDLE;
                end else if (haltCommand) begin
                    s_nxt.mode = SMC_HALT;
                end else if (s_r.subclockSelect) begin
                    s_nxt.mode = SMC_SUB;
                end
            end
            SMC_HALT: begin
                if (haltWake) begin
                    s_nxt.mode = SMC_NORMAL;
                    s_nxt.wakePulse = 1'b1;
                end
            end
            SMC_IDLE: begin
                if (idleWake) begin
                    s_nxt.mode = SMC_NORMAL;
                    if (!pscSet) s_nxt.power_save_control.standbySelect = 1'b0;
                    s_nxt.wakePulse = 1'b1;
                end
            end
            SMC_STOP: begin
                if (stopWake) begin
                    s_nxt.mode = SMC_NORMAL;
                    if (!pscSet) s_nxt.power_save_control.standbySelect = 1'b0;
                    s_nxt.wakePulse = 1'b1;
                end
            end
            SMC_SUB: begin
                if (s_r.power_save_control.standbySelect) begin
                    s_nxt.mode = SMC_SUBIDLE;
                end else if (!s_r.subclockSelect) begin
                    s_nxt.mode = SMC_NORMAL;
                end
            end
            SMC_SUBIDLE: begin
                if (subIdleWake) begin
                    s_nxt.mode = SMC_SUB;
                    if (!pscSet) s_nxt.power_save_control.standbySelect = 1'b0;
                    s_nxt.wakePulse = 1'b1;
                end
            end
            default: begin
                s_nxt.mode = SMC_NORMAL;
            end
        endcase
        s_nxt.clk = clocksFor(s_nxt.mode, s_nxt.pllEnable);
        // A watchdog reset, except watchdog 1 on the subclock, raises sysResetReq and returns all else to reset values
        if (anyReset) begin
            s_nxt = '0;
            s_nxt.clk = smc_clk_s'(`SMC_CLK_OUT_RESET);
            s_nxt.sysResetReq = 1'b1;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r     <= '0;
            s_r.clk <= smc_clk_s'(`SMC_CLK_OUT_RESET);
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state; waitrequest also uses the bus request and ce
    assign avsRsp.waitrequest = busReq & ~(s_r.ack & ce);
    assign avsRsp.readdata    = s_r.rdata;
    assign clkCtl      = s_r.clk;
    assign mode        = s_r.mode;
    assign sysResetReq = s_r.sysResetReq;
    assign wakePulse   = s_r.wakePulse;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sProtectedWrite;
        taken && avsReq.write && laneLow && s_r.armed &&
        addr == `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_CONTROL);
    endsequence

    sequence sBareWrite;
        taken && avsReq.write && !s_r.armed && !anyReset &&
        (s_r.mode == SMC_NORMAL || s_r.mode == SMC_SUB) &&
        addr == `SMC_BYTE_ADDR(`SMC_IDX_POWER_SAVE_CONTROL);
    endsequence

    sequence sIdleBlockedWdt2;
        ce && !anyReset && s_r.mode == SMC_SUBIDLE &&
        s_r.power_save_control.wdt2ReleaseBlock && !wakeSrc.nmiPin &&
        wakeSrc.externalIrqPins == 8'h00 && !wakeSrc.subIdlePeriphIrq;
    endsequence

    AST_HALT_CLOCKS: assert property (
        s_r.mode == SMC_HALT |-> !clkCtl.cpuClkEn &&
        clkCtl.periphClkEn && clkCtl.mainOscEn && clkCtl.subOscEn)
        else $error("halt clock gating wrong");
    AST_IDLE_CLOCKS: assert property (
        s_r.mode == SMC_IDLE |-> !clkCtl.periphClkEn &&
        clkCtl.mainOscEn && clkCtl.pllEn == s_r.pllEnable)
        else $error("idle clock gating wrong");
    AST_STOP_CLOCKS: assert property (
        s_r.mode == SMC_STOP |-> !clkCtl.mainOscEn && !clkCtl.pllEn &&
        clkCtl.subOscEn && !clkCtl.cpuClkEn)
        else $error("stop clock gating wrong");
    AST_SUB_SELECT: assert property (
        clkCtl.sysClkSel == onSubclock)
        else $error("system clock select disagrees with mode");
    AST_HALT_ENTRY: assert property (
        ce && !anyReset && s_r.mode == SMC_NORMAL &&
        !s_r.power_save_control.standbySelect && haltCommand |=> s_r.mode == SMC_HALT)
        else $error("halt not entered");
    AST_HALT_WAKE: assert property (
        ce && !anyReset && s_r.mode == SMC_HALT && wakeSrc.maskableIrq
        |=> s_r.mode == SMC_NORMAL && wakePulse)
        else $error("halt not released");
    AST_STOP_PIN_WAKE: assert property (
        ce && !anyReset && s_r.mode == SMC_STOP && wakeSrc.nmiPin &&
        wakeSrc.externalIrqPins == 8'h00 && !wakeSrc.stopPeriphIrq
        |=> (s_r.mode == SMC_NORMAL) == !$past(s_r.power_save_control.pinNonmaskReleaseBlock))
        else $error("pin release block ignored");
    AST_WDT2_BLOCK: assert property (
        sIdleBlockedWdt2 |=> s_r.mode == SMC_SUBIDLE)
        else $error("blocked watchdog 2 released subclock idle");
    AST_PROTECTED_WRITE: assert property (
        sBareWrite |=> $stable(s_r.power_save_control))
        else $error("unprotected write changed control register");
    AST_MASK_IGNORED: assert property (
        sProtectedWrite ##0 avsReq.writedata[`SMC_PSC_STANDBY_BIT] &&
        !anyReset && (avsReq.writedata[7:0] & 8'hB0) != 8'h00
        |=> s_r.power_save_control[3:1] == $past(s_r.power_save_control[3:1]))
        else $error("mask written with standby-select took effect");
    AST_SUB_RESET: assert property (
        ce && onSubclock && rstSrc.watchdog1Reset &&
        !rstSrc.watchdog2Reset |=> !sysResetReq)
        else $error("watchdog 1 reset acted on subclock");
    AST_SUBIDLE_RETURN: assert property (
        ce && !anyReset && s_r.mode == SMC_SUBIDLE && wakeSrc.nmiPin &&
        !s_r.power_save_control.pinNonmaskReleaseBlock |=> s_r.mode == SMC_SUB
        ##1 s_r.mode != SMC_SUBIDLE || s_r.power_save_control.standbySelect)
        else $error("subclock idle did not return to subclock");

endmodule // smc_standby_controller
`default_nettype wire

// ---- testbench/test_standby_mode_controller.sv ----
// Self-checking bench of the standby-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module test_standby_mode_controller;
    import smc_pkg::*;

    localparam logic [31:0] CTRL = `SMC_IDX_POWER_SAVE_CONTROL;
    localparam logic [31:0] PROT = `SMC_IDX_PROTECT_COMMAND;

    logic         clk;
    logic         nrst;
    logic         ce;
    smc_avs_req_s avsReq;
    smc_avs_rsp_s avsRsp;
    logic         haltCommand;
    smc_wake_s    wakeSrc;
    smc_rst_s     rstSrc;
    smc_clk_s     clkCtl;
    smc_mode_e    mode;
    logic         sysResetReq;
    logic         wakePulse;
    logic         snap;
    logic [31:0]  rdQ[$];
    logic [31:0]  snQ[$];
    int           mismatches;
    int           checksDone;
    int           cycles;
    logic [7:0]   rnd;
    smc_wake_s    w;
    logic [7:0]   blk;

    smc_standby_controller uut (
        .clk         (clk),
        .nrst        (nrst),
        .ce          (ce),
        .avsReq      (avsReq),
        .avsRsp      (avsRsp),
        .haltCommand (haltCommand),
        .wakeSrc     (wakeSrc),
        .rstSrc      (rstSrc),
        .clkCtl      (clkCtl),
        .mode        (mode),
        .sysResetReq (sysResetReq),
        .wakePulse   (wakePulse)
    );

    // Free-running 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Snapshot word: reset pulse, wake pulse, mode, clock enables
    function automatic logic [31:0] ex(input logic r, input logic p,
                                       input smc_mode_e m,
                                       input logic [5:0] c);
        return {21'h0, r, p, m, c};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && checksDone > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Monitor at the rising edge; sees the cycle that this edge closes
    always @(posedge clk) begin
        if (avsReq.read && avsRsp.waitrequest === 1'b0) begin
            if (rdQ.size() == 0) check(avsRsp.readdata, 32'hFFFFFFFF);
            else check(avsRsp.readdata, rdQ.pop_front());
        end
        if (snap) check({21'h0, sysResetReq, wakePulse, mode, clkCtl},
                        snQ.pop_front());
    end

    // Hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            results();
        end
    end

    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [31:0] idx,
                       input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        avsReq.read       <= ~wr;
        avsReq.write      <= wr;
        avsReq.address    <= `SMC_BYTE_ADDR(idx);
        avsReq.writedata  <= {24'h0, d};
        avsReq.byteenable <= 4'hF;
        if (!wr) rdQ.push_back({24'h0, e});
        do @(posedge clk); while (avsRsp.waitrequest !== 1'b0);
        avsReq.read  <= 1'b0;
        avsReq.write <= 1'b0;
    endtask

    // Protected sequence: arm, then the target write
    task automatic pw(input logic [31:0] idx, input logic [7:0] d);
        bus(1'b1, PROT, 8'h00, 8'h00);
        bus(1'b1, idx, d, 8'h00);
    endtask

    task automatic snapNow(input logic [31:0] e);
        snQ.push_back(e);
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
    endtask

    // Standby request; mode moves one edge after the register
    task automatic enter(input logic [7:0] d, input logic [31:0] e);
        pw(CTRL, d);
        @(posedge clk);
        snapNow(e);
    endtask

    // One-cycle pulse on wake, reset or halt inputs, then snapshot
    task automatic poke(input smc_wake_s pw_, input smc_rst_s pr,
                        input logic ph, input logic [31:0] e);
        @(posedge clk);
        wakeSrc     <= pw_;
        rstSrc      <= pr;
        haltCommand <= ph;
        @(posedge clk);
        wakeSrc     <= '0;
        rstSrc      <= '0;
        haltCommand <= 1'b0;
        snapNow(e);
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0; ce = 1'b1; avsReq = '0; haltCommand = 1'b0;
        wakeSrc = '0; rstSrc = '0; snap = 1'b0;
        mismatches = 0; checksDone = 0; cycles = 0; rnd = 8'h35; w = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, CTRL, 8'h00, 8'h00);
        bus(1'b0, 32'h00000010, 8'h00, 8'h00);
        bus(1'b1, CTRL, 8'hB0, 8'h00);
        bus(1'b0, CTRL, 8'h00, 8'h00);
        bus(1'b1, PROT, 8'h00, 8'h00);
        bus(1'b0, `SMC_IDX_STATUS, 8'h00, 8'h08);
        bus(1'b1, CTRL, 8'h30, 8'h00);
        bus(1'b0, CTRL, 8'h00, 8'h30);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            pw(CTRL, rnd & 8'hFD);
            bus(1'b0, CTRL, 8'h00, rnd & 8'hB0);
        end
        pw(CTRL, 8'h00);
        pw(`SMC_IDX_PSC_SET, 8'h10);
        bus(1'b0, CTRL, 8'h00, 8'h10);
        pw(`SMC_IDX_PSC_CLEAR, 8'h10);
        bus(1'b0, CTRL, 8'h00, 8'h00);
        // Masks written together with standby-select are dropped
        enter(8'hB2, ex(0, 0, SMC_IDLE, 6'h0A));
        bus(1'b0, CTRL, 8'h00, 8'h02);
        w = '0; w.externalIrqPins = 8'h80;
        poke(w, '0, 1'b0, ex(0, 1, SMC_NORMAL, 6'h3A));
        bus(1'b0, CTRL, 8'h00, 8'h00);
        // The pin and maskable block bits each stop their own source only
        for (int i = 0; i < 2; i++) begin
            blk = i ? 8'h10 : 8'h20;
            pw(CTRL, blk);
            enter(blk | 8'h02, ex(0, 0, SMC_IDLE, 6'h0A));
            w = '0;
            if (i) w.externalIrqPins = 8'h01;
            else w.nmiPin = 1'b1;
            poke(w, '0, 1'b0, ex(0, 0, SMC_IDLE, 6'h0A));
            w = '0;
            if (i) w.nmiPin = 1'b1;
            else w.idlePeriphIrq = 1'b1;
            poke(w, '0, 1'b0, ex(0, 1, SMC_NORMAL, 6'h3A));
        end
        pw(CTRL, 8'h00);
        bus(1'b1, `SMC_IDX_CLOCK_CONTROL, 8'h00, 8'h00);
        bus(1'b1, `SMC_IDX_POWER_SAVE_MODE, 8'h01, 8'h00);
        enter(8'h02, ex(0, 0, SMC_STOP, 6'h02));
        w = '0; w.idlePeriphIrq = 1'b1; w.watchdog2NonmaskRequest = 1'b1;
        poke(w, '0, 1'b0, ex(0, 0, SMC_STOP, 6'h02));
        w = '0; w.stopPeriphIrq = 1'b1;
        poke(w, '0, 1'b0, ex(0, 1, SMC_NORMAL, 6'h3A));
        enter(8'h02, ex(0, 0, SMC_STOP, 6'h02));
        w = '0; w.nmiPin = 1'b1;
        poke(w, '0, 1'b0, ex(0, 1, SMC_NORMAL, 6'h3A));
        bus(1'b1, `SMC_IDX_POWER_SAVE_MODE, 8'h00, 8'h00);
        // Clock enable low: a halt command must not be taken
        ce          <= 1'b0;
        haltCommand <= 1'b1;
        @(posedge clk);
        snapNow(ex(0, 0, SMC_NORMAL, 6'h3A));
        ce          <= 1'b1;
        haltCommand <= 1'b0;
        poke('0, '0, 1'b1, ex(0, 0, SMC_HALT, 6'h1A));
        w = '0; w.maskableIrq = 1'b1;
        poke(w, '0, 1'b0, ex(0, 1, SMC_NORMAL, 6'h3A));
        bus(1'b1, `SMC_IDX_CLOCK_CONTROL, 8'h01, 8'h00);
        @(posedge clk);
        snapNow(ex(0, 0, SMC_SUB, 6'h3B));
        poke('0, 2'b10, 1'b0, ex(0, 0, SMC_SUB, 6'h3B));
        enter(8'h02, ex(0, 0, SMC_SUBIDLE, 6'h0B));
        w = '0; w.watchdog2NonmaskRequest = 1'b1;
        poke(w, '0, 1'b0, ex(0, 1, SMC_SUB, 6'h3B));
        // Watchdog 2 blocked in subclock idle; the pin still wakes
        pw(CTRL, 8'h80);
        enter(8'h82, ex(0, 0, SMC_SUBIDLE, 6'h0B));
        poke(w, '0, 1'b0, ex(0, 0, SMC_SUBIDLE, 6'h0B));
        w = '0; w.nmiPin = 1'b1;
        poke(w, '0, 1'b0, ex(0, 1, SMC_SUB, 6'h3B));
        poke('0, 2'b01, 1'b0, ex(1, 0, SMC_NORMAL, 6'h3A));
        bus(1'b0, `SMC_IDX_CLOCK_CONTROL, 8'h00, 8'h00);
        pw(CTRL, 8'h30);
        poke('0, 2'b10, 1'b0, ex(1, 0, SMC_NORMAL, 6'h3A));
        bus(1'b0, CTRL, 8'h00, 8'h00);
        repeat (2) @(posedge clk);
        results();
    end

endmodule // test_standby_mode_controller

`default_nettype wire
